// ==== hw/tbs_pkg.sv ====
// Shared constants, types and frame carriers for the Type B slot anticollision block
`default_nettype none
package tbs_pkg;

   // Card protocol states
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_READY  = 2'b01,
      ST_ACTIVE = 2'b10,
      ST_HALT   = 2'b11
   } tbsCard_e;

   // Command codes and field values
   localparam logic [7:0]  CMD_REQB        = 8'h05;   // REQB and WUPB share this code
   localparam logic [7:0]  CMD_HLTB        = 8'h50;
   localparam logic [7:0]  CMD_ATTRIB      = 8'h1D;
   localparam logic [7:0]  CMD_DESEL       = 8'hC2;   // Deselect without CID byte
   localparam logic [7:0]  CMD_DESEL_CID   = 8'hCA;   // Deselect with CID byte
   localparam logic [3:0]  SLOT_CMD_NIB    = 4'h5;    // Low nibble of a slot marker
   localparam int          WUPB_BIT        = 3;       // Param bit that marks wake-up
   localparam logic [2:0]  N_CODE_MAX      = 3'h4;    // Codes above give no valid N

   // Data lengths of request frames, CRC bytes excluded
   localparam logic [3:0]  LEN_REQB        = 4'h3;
   localparam logic [3:0]  LEN_SLOT        = 4'h1;
   localparam logic [3:0]  LEN_HLTB        = 4'h5;
   localparam logic [3:0]  LEN_ATTRIB      = 4'h9;
   localparam logic [3:0]  LEN_DESEL       = 4'h1;
   localparam logic [3:0]  LEN_DESEL_CID   = 4'h2;
   localparam logic [3:0]  CRC_BYTES       = 4'h2;
   localparam int          BUF_BYTES       = 9;       // Longest header kept: ATTRIB

   // CRC_B constants (bit-reversed polynomial x^16+x^12+x^5+1)
   localparam logic [15:0] CRC_PRESET      = 16'hFFFF;
   localparam logic [15:0] CRC_POLY_REV    = 16'h8408;
   localparam logic [15:0] CRC_RESIDUE     = 16'hF0B8; // Remainder after data plus inverted CRC
   localparam logic [4:0]  CRC_BITS        = 5'h10;

   // Reset values and LFSR taps
   localparam logic [15:0] LFSR_SEED       = 16'hACE1;
   localparam logic [15:0] LFSR_TAPS       = 16'hB400;
   localparam logic [3:0]  CID_RESET       = 4'h0;
   localparam logic [4:0]  SLOT_RESET      = 5'h01;

   // Received frame strobes
   typedef struct packed {
      logic       start;   // First byte of a frame follows or comes now
      logic       valid;   // Data byte strobe
      logic [7:0] data;    // Byte, bit 0 first on air
      logic       last;    // Frame ended, all bytes delivered
   } tbsRxFrame_s;

   // Transmitted frame strobes
   typedef struct packed {
      logic       start;   // Preset the transmit CRC
      logic       valid;   // Data byte strobe
      logic [7:0] data;
      logic       crcReq;  // Data done, shift the CRC out
   } tbsTxFrame_s;

   // Reply requests to the frame builder
   typedef struct packed {
      logic atqb;
      logic attrib;
      logic halt;
      logic deselect;
   } tbsReply_s;

endpackage : tbs_pkg
`default_nettype wire

// ==== hw/tbs_crc.sv ====
// CRC_B byte-wise generator and checker register
`timescale 1ns/1ps
`default_nettype none
module tbs_crc (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // Byte stream
   input  wire logic        init,
   input  wire logic        byteValid,
   input  wire logic [7:0]  byteIn,
   // Running remainder
   output logic      [15:0] crc
);
   import tbs_pkg::*;

   typedef struct packed {
      logic [15:0] crc;
   } tbsCrcState_s;

   tbsCrcState_s state_q;   // Registered state
   tbsCrcState_s state_d;   // Next state

   // Fold one byte into the remainder, least significant bit first
   function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         if (r[0] ^ d[i]) begin
            r = (r >> 1) ^ CRC_POLY_REV; // R14
         end else begin
            r = r >> 1;
         end
      end
      return r;
   endfunction : crcByte

   // Preset on frame start; a byte in the same cycle is folded onto the preset
   always_comb begin
      logic [15:0] base;
      base    = init ? CRC_PRESET : state_q.crc; // R18
      state_d = state_q;
      state_d.crc = byteValid ? crcByte(base, byteIn) : base;
   end

   // State register
   always_ff @(posedge clk) begin
      if (reset) begin
         state_q.crc <= CRC_PRESET;
      end else begin
         state_q <= state_d;
      end
   end

   assign crc = state_q.crc;

endmodule : tbs_crc
`default_nettype wire

// ==== hw/tbs_anticoll.sv ====
// Card-side Type B time-slot anticollision, command filter and CRC_B handling
//
// Overview of operation
// R1: WUPB takes part only on AFI match
// R2: REQB ignored in HALT, else like WUPB
// R3: Param N gives number of slots
// R4: N of one: answer ATQB at once
// R5: N above one: draw R, answer if one
// R6: R above one: answer matching slot marker
// R7: Reader probes every slot from 2 to N
// R8: Reader halts or activates answered card by PUPI
// R9: ACTIVE ignores all but DESELECT
// R10: Reader treats bad ATQB CRC as collision
// R11: New REQB redraws R for non-halted cards
// R12: Reader settles other slots before new round
// R13: Slot markers may come in any order
// R14: Frames carry CRC, polynomial x16+x12+x5+1
// R15: CRC sent bit-inverted
// R16: CRC copied to shifter, sent LSB first
// R17: DESELECT answered only on CID match
// R18: CRC preset to all ones per frame
// R19: One ATQB per round only
`timescale 1ns/1ps
`default_nettype none
module tbs_anticoll (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               reset,
   // Received frames from the demodulator
   input  wire tbs_pkg::tbsRxFrame_s rxFrame,
   // Outgoing frame bytes from the frame builder
   input  wire tbs_pkg::tbsTxFrame_s txFrame,
   // Card identity
   input  wire logic [7:0]         ownAfi,
   input  wire logic [31:0]        ownPupi,
   // Reply requests and card status
   output tbs_pkg::tbsReply_s      reply,
   output tbs_pkg::tbsCard_e       cardState,
   output logic [3:0]              assignedCid,
   output logic [4:0]              slotNumber,
   output logic                    rxCrcError,
   // Serial CRC for transmission
   output logic                    crcBit,
   output logic                    crcBitValid
);
   import tbs_pkg::*;

   // Whole module state
   typedef struct packed {
      tbsCard_e                       card;      // Protocol state
      logic [3:0]                     cid;       // CID given by ATTRIB
      logic [4:0]                     slot;      // Drawn slot R, 1..16
      logic                           answered;  // ATQB already sent this round
      logic [15:0]                    lfsr;      // Free-running random source
      logic [3:0]                     count;     // Bytes received, saturating
      logic [BUF_BYTES-1:0][7:0]      head;      // Leading frame bytes
      tbsReply_s                      reply;     // One-cycle reply pulses
      logic                           crcErr;    // One-cycle bad CRC pulse
      logic [15:0]                    txShift;   // CRC shifter
      logic [4:0]                     txCount;   // CRC bits left
   } tbsState_s;

   tbsState_s   state_q;   // Registered state
   tbsState_s   state_d;   // Next state
   logic [15:0] rxCrc;     // Receive remainder
   logic [15:0] txCrc;     // Transmit remainder

   // Receive checker
   tbs_crc u_rx_crc (
      .clk       (clk),
      .reset     (reset),
      .init      (rxFrame.start),
      .byteValid (rxFrame.valid),
      .byteIn    (rxFrame.data),
      .crc       (rxCrc)
   );

   // Transmit generator
   tbs_crc u_tx_crc (
      .clk       (clk),
      .reset     (reset),
      .init      (txFrame.start),
      .byteValid (txFrame.valid),
      .byteIn    (txFrame.data),
      .crc       (txCrc)
   );

   // AFI zero selects all cards; a zero low nibble selects a whole family
   function automatic logic afiMatch(input logic [7:0] req, input logic [7:0] own);
      logic m;
      if (req == 8'h00) begin
         m = 1'b1;
      end else if (req[3:0] == 4'h0) begin
         m = (req[7:4] == own[7:4]);
      end else begin
         m = (req == own);
      end
      return m;
   endfunction : afiMatch

   // PUPI sits in bytes 1 to 4 of a halt or attribute request, byte 1 lowest
   function automatic logic pupiMatch(input logic [BUF_BYTES-1:0][7:0] h, input logic [31:0] own);
      return ({h[4], h[3], h[2], h[1]} == own);
   endfunction : pupiMatch

   // Main next-state logic
   always_comb begin
      logic [3:0]  dataLen;
      logic        frameOk;
      logic [4:0]  nSlots;
      logic [4:0]  drawn;
      logic        isWakeup;
      logic [4:0]  markerSlot;
      dataLen    = state_q.count - CRC_BYTES;
      frameOk    = 1'b0;
      nSlots     = 5'h01;
      drawn      = 5'h01;
      isWakeup   = 1'b0;
      markerSlot = 5'h00;
      state_d    = state_q;

      // Pulses last a single cycle
      state_d.reply  = '0;
      state_d.crcErr = 1'b0;

      // Random source advances every cycle so the draw depends on arrival time
      state_d.lfsr = state_q.lfsr[0] ? ((state_q.lfsr >> 1) ^ LFSR_TAPS) : (state_q.lfsr >> 1);

      // Capture frame bytes; start may coincide with the first byte
      if (rxFrame.start) begin
         state_d.count = 4'h0;
      end
      if (rxFrame.valid) begin
         if (state_d.count < 4'(BUF_BYTES)) begin
            state_d.head[state_d.count] = rxFrame.data;
         end
         if (state_d.count != 4'hF) begin
            state_d.count = state_d.count + 4'h1;
         end
      end

      // Frame end: check CRC and decode
      if (rxFrame.last) begin
         frameOk = (state_q.count >= CRC_BYTES) && (rxCrc == CRC_RESIDUE); // R14 R15
         state_d.crcErr = !frameOk;
         if (frameOk) begin
            if (state_q.head[0] == CMD_REQB && dataLen == LEN_REQB) begin
               // REQB or WUPB
               isWakeup = state_q.head[2][WUPB_BIT];
               if (state_q.card != ST_ACTIVE                                // R9
                   && !(state_q.card == ST_HALT && !isWakeup)              // R2
                   && afiMatch(state_q.head[1], ownAfi)                    // R1
                   && state_q.head[2][2:0] <= N_CODE_MAX) begin
                  nSlots = 5'h01 << state_q.head[2][2:0];                   // R3
                  drawn  = 5'((state_q.lfsr[3:0] & 4'(nSlots - 5'h01))) + 5'h01; // R5 R11
                  state_d.card     = ST_READY;
                  state_d.slot     = drawn;
                  state_d.answered = 1'b0;                                 // R19
                  if (drawn == 5'h01) begin
                     state_d.reply.atqb = 1'b1;                             // R4 R5
                     state_d.answered   = 1'b1;
                  end
               end
            end else if (state_q.head[0][3:0] == SLOT_CMD_NIB && state_q.head[0][7:4] != 4'h0
                         && dataLen == LEN_SLOT) begin
               // Slot marker carries slot minus one in its high nibble
               markerSlot = {1'b0, state_q.head[0][7:4]} + 5'h01;
               if (state_q.card == ST_READY && !state_q.answered             // R9 R19
                   && markerSlot == state_q.slot) begin                     // R6 R13
                  state_d.reply.atqb = 1'b1;
                  state_d.answered   = 1'b1;
               end
            end else if (state_q.head[0] == CMD_HLTB && dataLen == LEN_HLTB) begin
               // Halt by PUPI, only while taking part in a round
               if (state_q.card == ST_READY                                 // R9
                   && pupiMatch(state_q.head, ownPupi)) begin
                  state_d.card       = ST_HALT;                             // R8
                  state_d.reply.halt = 1'b1;
               end
            end else if (state_q.head[0] == CMD_ATTRIB && dataLen >= LEN_ATTRIB) begin
               // Activate by PUPI and take the CID; reserved CID 15 is refused
               if (state_q.card == ST_READY && state_q.head[8][3:0] != 4'hF  // R9
                   && pupiMatch(state_q.head, ownPupi)) begin
                  state_d.card         = ST_ACTIVE;                         // R8
                  state_d.cid          = state_q.head[8][3:0];
                  state_d.reply.attrib = 1'b1;
               end
            end else if (state_q.head[0] == CMD_DESEL && dataLen == LEN_DESEL) begin
               // Deselect without CID reaches only a card holding CID zero
               if (state_q.card == ST_ACTIVE && state_q.cid == 4'h0) begin  // R17
                  state_d.card           = ST_HALT;
                  state_d.reply.deselect = 1'b1;
               end
            end else if (state_q.head[0] == CMD_DESEL_CID && dataLen == LEN_DESEL_CID) begin
               if (state_q.card == ST_ACTIVE && state_q.head[1][3:0] == state_q.cid) begin // R17
                  state_d.card           = ST_HALT;
                  state_d.reply.deselect = 1'b1;
               end
            end else begin
               // Other commands are left to the block protocol layer
               state_d.card = state_q.card;
            end
         end
      end

      // CRC shift-out; a new request restarts the shifter even mid-send
      if (txFrame.crcReq) begin
         state_d.txShift = ~txCrc;                                         // R15 R16
         state_d.txCount = CRC_BITS;
      end else if (state_q.txCount != 5'h00) begin
         state_d.txShift = state_q.txShift >> 1;                           // R16
         state_d.txCount = state_q.txCount - 5'h01;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (reset) begin
         state_q.card     <= ST_IDLE;
         state_q.cid      <= CID_RESET;
         state_q.slot     <= SLOT_RESET;
         state_q.answered <= 1'b0;
         state_q.lfsr     <= LFSR_SEED;
         state_q.count    <= 4'h0;
         state_q.head     <= '0;
         state_q.reply    <= '0;
         state_q.crcErr   <= 1'b0;
         state_q.txShift  <= 16'h0000;
         state_q.txCount  <= 5'h00;
      end else begin
         state_q <= state_d;
      end
   end

   // Outputs straight from the state register
   assign reply       = state_q.reply;
   assign cardState   = state_q.card;
   assign assignedCid = state_q.cid;
   assign slotNumber  = state_q.slot;
   assign rxCrcError  = state_q.crcErr;
   assign crcBit      = state_q.txShift[0];
   assign crcBitValid = (state_q.txCount != 5'h00);

endmodule : tbs_anticoll
`default_nettype wire

// ==== verif/tbs_anticoll_props.sv ====
// Concurrent checks on the ports of the Type B slot anticollision block
`timescale 1ns/1ps
`default_nettype none
module tbs_anticoll_props
   import tbs_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // Frames
   input  wire tbsRxFrame_s rxFrame,
   input  wire tbsTxFrame_s txFrame,
   // Status and replies
   input  wire tbsReply_s   reply,
   input  wire tbsCard_e    cardState,
   input  wire logic [3:0]  assignedCid,
   input  wire logic [4:0]  slotNumber,
   input  wire logic        rxCrcError,
   input  wire logic        crcBit,
   input  wire logic        crcBitValid
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   AST_REPLY_AFTER_LAST: assert property (({reply, rxCrcError} != 5'h00) |-> $past(rxFrame.last))
      else $error("reply without a frame end");
   AST_ONE_RESULT: assert property ($onehot0({reply, rxCrcError}))
      else $error("more than one result at once");
   AST_ATQB_READY: assert property (reply.atqb |-> cardState == ST_READY && $past(cardState) != ST_ACTIVE)
      else $error("answer request outside ready");
   AST_ACTIVE_SILENT: assert property (cardState == ST_ACTIVE && rxFrame.last |=> !reply.atqb && !reply.halt)
      else $error("active card answered a filtered command");
   AST_ATTRIB_STEP: assert property (reply.attrib |-> cardState == ST_ACTIVE && assignedCid != 4'hF)
      else $error("attribute reply without activation");
   AST_DESEL_STEP: assert property (reply.deselect |-> cardState == ST_HALT && $past(cardState) == ST_ACTIVE)
      else $error("deselect reply from wrong state");
   AST_STATE_HOLD: assert property (!$past(rxFrame.last) |-> $stable(cardState))
      else $error("state moved without a frame");
   AST_SLOT_RANGE: assert property (slotNumber >= 5'h01 && slotNumber <= 5'h10)
      else $error("slot number out of range");
   AST_CRC_START: assert property (txFrame.crcReq |=> crcBitValid)
      else $error("crc shift did not start");
   AST_CRC_LEN: assert property ($rose(crcBitValid) |-> crcBitValid [*8] ##1 crcBitValid [*8] ##1 !crcBitValid)
      else $error("crc shift length wrong");
endmodule : tbs_anticoll_props

bind tbs_anticoll tbs_anticoll_props u_props (.clk(clk), .reset(reset), .rxFrame(rxFrame), .txFrame(txFrame),
   .reply(reply), .cardState(cardState), .assignedCid(assignedCid), .slotNumber(slotNumber),
   .rxCrcError(rxCrcError), .crcBit(crcBit), .crcBitValid(crcBitValid));
`default_nettype wire

// ==== verif/tbs_reader_model.sv ====
// Reader model that frames requests with an inverted CRC
`timescale 1ns/1ps
`default_nettype none
module tbs_reader_model
   import tbs_pkg::*;
(
   // Clock
   input  wire logic        clk,
   // Frame towards the card
   output var tbsRxFrame_s  rxFrame
);
   initial rxFrame = '0;

   // Bitwise CRC, preset to ones, low bit first
   function automatic logic [15:0] crcB(input logic [71:0] d, input int n);
      logic [15:0] c;
      c = CRC_PRESET;
      for (int i = 0; i < 8 * n; i++)
         c = (c >> 1) ^ ((c[0] ^ d[i]) ? CRC_POLY_REV : 16'h0000);
      return c;
   endfunction : crcB

   // Bytes go out lowest first; bad flips one CRC bit to fake a collision
   task automatic sendFrame(input logic [71:0] d, input int n, input bit bad);
      logic [87:0] f;
      f = {16'h0000, d};
      f[8 * n +: 16] = ~crcB(d, n) ^ (bad ? 16'h0100 : 16'h0000);
      for (int i = 0; i < n + 2; i++) begin
         @(negedge clk);
         rxFrame.start = (i == 0);
         rxFrame.valid = 1'b1;
         rxFrame.data  = f[8 * i +: 8];
      end
      @(negedge clk);
      rxFrame.start = 1'b0;
      rxFrame.valid = 1'b0;
      rxFrame.last  = 1'b1;
      rxFrame.data  = ~rxFrame.data; // Released line must not echo the last byte
      @(negedge clk);
      rxFrame.last  = 1'b0;
      rxFrame.data  = ~rxFrame.data;
   endtask : sendFrame
endmodule : tbs_reader_model
`default_nettype wire

// ==== verif/tbs_anticoll_tb.sv ====
// Self-checking testbench for the Type B slot anticollision block
`timescale 1ns/1ps
`default_nettype none
module tbs_anticoll_tb;
   import tbs_pkg::*;
   // Stimulus and outputs
   logic        clk;
   logic        reset;
   tbsRxFrame_s rxFrame;
   tbsTxFrame_s txFrame;
   logic [7:0]  ownAfi;
   logic [31:0] ownPupi;
   tbsReply_s   reply;
   tbsCard_e    cardState;
   logic [3:0]  assignedCid;
   logic [4:0]  slotNumber;
   logic        rxCrcError;
   logic        crcBit;
   logic        crcBitValid;
   // Scoreboard state
   int          errors;
   int          checks;
   logic [4:0]  expQ[$];  // {atqb, attrib, halt, deselect, crc error}
   logic        bitQ[$];
   logic        free;     // Round start: answer depends on the drawn slot
   logic        saw;
   logic [4:0]  r;
   logic [31:0] rng;
   logic [71:0] txd;
   logic [15:0] crc;

   tbs_reader_model u_rdr (.clk(clk), .rxFrame(rxFrame));
   tbs_anticoll u_dut (.clk(clk), .reset(reset), .rxFrame(rxFrame), .txFrame(txFrame), .ownAfi(ownAfi),
      .ownPupi(ownPupi), .reply(reply), .cardState(cardState), .assignedCid(assignedCid),
      .slotNumber(slotNumber), .rxCrcError(rxCrcError), .crcBit(crcBit), .crcBitValid(crcBitValid));

   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction : xs

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk

   // Note the expected result, then send the frame and let the reply land
   task automatic req(input logic [71:0] d, input int n, input bit bad, input logic [4:0] exp);
      if (exp != 5'h00)
         expQ.push_back(exp);
      u_rdr.sendFrame(d, n, bad);
      repeat (3) @(negedge clk);
   endtask : req

   task automatic stop_test();
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   // Monitor: a result pulse at a round start must be an ATQB; any other takes the oldest note
   always @(posedge clk) begin
      #1;
      if (!reset && ({reply, rxCrcError} !== 5'h00)) begin
         if (free) begin
            saw = reply.atqb;
            chk({reply, rxCrcError}, 5'h10);
         end
         else
            chk({reply, rxCrcError}, expQ.size() ? expQ.pop_front() : 32'hFFFF_FFFF);
      end
      // A result with no note behind it meets a value that no output can show
      if (!reset && crcBitValid === 1'b1)
         chk(crcBit, bitQ.size() ? bitQ.pop_front() : 32'hFFFF_FFFF);
   end

   // Hang guard
   initial begin
      repeat (30000) @(posedge clk);
      errors++;
      stop_test();
   end

   // Main sequence
   initial begin
      errors = 0;
      checks = 0;
      free = 1'b0;
      rng = 32'd32549;
      reset = 1'b1;
      txFrame = '0;
      ownAfi = 8'h35;
      rng = xs(rng);
      ownPupi = rng;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      chk(cardState, ST_IDLE);
      chk(slotNumber, SLOT_RESET);
      req({8'h08, 8'h40, CMD_REQB}, 3, 1'b0, 5'h00);
      req({8'h00, 8'h00, CMD_REQB}, 3, 1'b0, 5'h10);
      chk(cardState, ST_READY);
      // Rounds of 2, 4, 8 and 16 slots, markers probed highest first
      for (int c = 1; c <= 4; c++) begin
         free = 1'b1;
         saw = 1'b0;
         req({5'h00, c[2:0], 8'h30, CMD_REQB}, 3, 1'b0, 5'h00);
         free = 1'b0;
         r = slotNumber;
         chk(r >= 5'h01 && r <= (5'h01 << c), 1);
         chk(saw, r == 5'h01);
         for (int s = 1 << c; s >= 2; s--)
            req({64'h0, 4'(s - 1), SLOT_CMD_NIB}, 1, 1'b0, (s == r) ? 5'h10 : 5'h00);
         if (r > 5'h01)
            req({64'h0, 4'(r - 1), SLOT_CMD_NIB}, 1, 1'b0, 5'h00);
      end
      req({~ownPupi, CMD_HLTB}, 5, 1'b0, 5'h00);
      req({ownPupi, CMD_HLTB}, 5, 1'b0, 5'h04);
      chk(cardState, ST_HALT);
      req({8'h00, 8'h30, CMD_REQB}, 3, 1'b0, 5'h00);
      req({8'h08, 8'h30, CMD_REQB}, 3, 1'b0, 5'h10);
      req({8'h03, 8'h01, 8'h00, 8'h00, ownPupi, CMD_ATTRIB}, 9, 1'b0, 5'h08);
      chk(cardState, ST_ACTIVE);
      chk(assignedCid, 4'h3);
      req({8'h08, 8'h30, CMD_REQB}, 3, 1'b0, 5'h00);
      req({64'h0, 8'h15}, 1, 1'b0, 5'h00);
      req({ownPupi, CMD_HLTB}, 5, 1'b0, 5'h00);
      req({64'h0, CMD_DESEL}, 1, 1'b0, 5'h00);
      req({56'h0, 8'h03, CMD_DESEL_CID}, 2, 1'b0, 5'h02);
      chk(cardState, ST_HALT);
      req({8'h08, 8'h30, CMD_REQB}, 3, 1'b1, 5'h01);
      chk(cardState, ST_HALT);
      // Reset in mid-run, held two cycles so no check sees a half-reset history
      reset = 1'b1;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      chk(cardState, ST_IDLE);
      chk(assignedCid, CID_RESET);
      chk(slotNumber, SLOT_RESET);
      // Exact family code: a near miss is ignored, the own code answers
      req({8'h08, 8'h36, CMD_REQB}, 3, 1'b0, 5'h00);
      req({8'h08, 8'h35, CMD_REQB}, 3, 1'b0, 5'h10);
      // Slot count code above the largest is not a valid N
      req({8'h05, 8'h35, CMD_REQB}, 3, 1'b0, 5'h00);
      // Reserved CID is refused, then CID zero is taken once
      req({8'h0F, 8'h01, 8'h00, 8'h00, ownPupi, CMD_ATTRIB}, 9, 1'b0, 5'h00);
      chk(cardState, ST_READY);
      req({8'h00, 8'h01, 8'h00, 8'h00, ownPupi, CMD_ATTRIB}, 9, 1'b0, 5'h08);
      req({8'h00, 8'h01, 8'h00, 8'h00, ownPupi, CMD_ATTRIB}, 9, 1'b0, 5'h00);
      chk(cardState, ST_ACTIVE);
      // Deselect without CID reaches a card holding CID zero
      req({64'h0, CMD_DESEL}, 1, 1'b0, 5'h02);
      chk(cardState, ST_HALT);
      // Transmit CRC of three random bytes
      @(negedge clk);
      txFrame.start = 1'b1;
      for (int i = 0; i < 3; i++) begin
         rng = xs(rng);
         txd[8 * i +: 8] = rng[7:0];
         txFrame.valid = 1'b1;
         txFrame.data = rng[7:0];
         @(negedge clk);
         txFrame.start = 1'b0;
      end
      txFrame.valid = 1'b0;
      crc = ~u_rdr.crcB({48'h0, txd[23:0]}, 3);
      for (int i = 0; i < 16; i++)
         bitQ.push_back(crc[i]);
      txFrame.crcReq = 1'b1;
      @(negedge clk);
      txFrame.crcReq = 1'b0;
      repeat (24) @(negedge clk);
      chk(bitQ.size(), 0);
      chk(expQ.size(), 0);
      stop_test();
   end
endmodule : tbs_anticoll_tb
`default_nettype wire
